//--- hw/bcm_exec.sv
// branch, call and byte move execution sequencer
`timescale 1ns/1ps
`include "bcm_consts.svh"

module bcm_exec (
    input wire logic CLOCK,
    input wire logic RSTN,
    output logic CODE_RD,
    output logic [15:0] CODE_ADDR,
    input wire logic [7:0] CODE_DATA,
    input wire logic [7:0] ACCUMULATOR_IN,
    input wire logic [15:0] DATA_POINTER_IN,
    input wire logic CARRY_IN,
    input wire logic [7:0] STACK_POINTER_IN,
    output logic [2:0] REG_SEL,
    input wire logic [7:0] REG_IN,
    output logic [7:0] BIT_ADDR,
    input wire logic BIT_VALUE,
    output logic [15:0] PC,
    output logic ACCUMULATOR_WE,
    output logic [7:0] ACCUMULATOR_WDATA,
    output logic RAM_WE,
    output logic [7:0] RAM_ADDR,
    output logic [7:0] RAM_WDATA,
    output logic STACK_POINTER_WE,
    output logic [7:0] STACK_POINTER_WDATA,
    output logic INSTR_DONE,
    output logic ILLEGAL
);

    ////////////////////////////////////////////////////////////////////////////////
    // decode
    function automatic bcm_pkg::bcm_dec_t decode(input logic [7:0] op);
        bcm_pkg::bcm_dec_t d;
        d = '{len: `BCM_LEN_1, last: `BCM_LAST_1, legal: 1'b1};
        case (op)
            `BCM_OP_IJMP: d = '{len: `BCM_LEN_1, last: `BCM_LAST_2, legal: 1'b1};
            `BCM_OP_JUMP_BIT_CLEAR: d = '{len: `BCM_LEN_3, last: `BCM_LAST_4, legal: 1'b1};
            `BCM_OP_JUMP_CARRY_CLEAR, `BCM_OP_JUMP_CARRY_SET,
            `BCM_OP_JUMP_NONZERO, `BCM_OP_JUMP_ZERO: begin
                d = '{len: `BCM_LEN_2, last: `BCM_LAST_3, legal: 1'b1};
            end
            `BCM_OP_LONG_CALL, `BCM_OP_LONG_JUMP: begin
                d = '{len: `BCM_LEN_3, last: `BCM_LAST_4, legal: 1'b1};
            end
            default: begin
                // unsupported opcodes retire as one-byte no-ops and are flagged
                d.legal = (op[7:3] == `BCM_OP_MOVAR);
            end
        endcase
        return d;
    endfunction

    function automatic logic [15:0] sext(input logic [7:0] rel);
        return {{8{rel[7]}}, rel};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // reset release
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer
    bcm_pkg::bcm_state_t s;
    bcm_pkg::bcm_state_t next_s;
    bcm_pkg::bcm_dec_t dec;
    logic fetch_byte;
    logic [7:0] rel;
    logic [15:0] seq_pc;
    logic [15:0] ret_pc;
    logic taken;

    always_comb begin
        dec = decode(s.op);
        // opcode byte always fetched; operands only as long as the length allows
        fetch_byte = (s.mc == 2'h0) || (s.mc < dec.len);
        rel = (s.op == `BCM_OP_JUMP_BIT_CLEAR) ? s.opnd2 : s.opnd1;
        seq_pc = s.pc + {14'h0000, dec.len};
        ret_pc = s.pc + {14'h0000, `BCM_LEN_3};
        case (s.op)
            `BCM_OP_JUMP_BIT_CLEAR: taken = !BIT_VALUE;
            `BCM_OP_JUMP_CARRY_CLEAR: taken = !CARRY_IN;
            `BCM_OP_JUMP_CARRY_SET: taken = CARRY_IN;
            `BCM_OP_JUMP_NONZERO: taken = |ACCUMULATOR_IN;
            `BCM_OP_JUMP_ZERO: taken = ~|ACCUMULATOR_IN;
            default: taken = 1'b0;
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.accumulator_we = 1'b0;
        next_s.ram_we = 1'b0;
        next_s.stack_pointer_we = 1'b0;
        next_s.done = 1'b0;
        next_s.illegal = 1'b0;
        case (s.phase)
            bcm_pkg::PH_ADDR: next_s.phase = bcm_pkg::PH_WAIT;
            bcm_pkg::PH_WAIT: next_s.phase = bcm_pkg::PH_TAKE;
            bcm_pkg::PH_TAKE: begin
                next_s.phase = bcm_pkg::PH_WORK;
                if (fetch_byte) begin
                    case (s.mc)
                        2'h0: next_s.op = CODE_DATA;
                        `BCM_MC_OPND1: next_s.opnd1 = CODE_DATA;
                        default: next_s.opnd2 = CODE_DATA;
                    endcase
                end
            end
            bcm_pkg::PH_WORK: begin
                next_s.phase = bcm_pkg::PH_ADDR;
                if (fetch_byte) begin
                    next_s.code_addr = s.code_addr + 16'h0001;
                end
                // stack writes use the pre-call pointer; it is only updated at retirement
                if (s.op == `BCM_OP_LONG_CALL && s.mc == `BCM_MC_OPND1) begin
                    next_s.ram_we = 1'b1;
                    next_s.ram_addr = STACK_POINTER_IN + `BCM_PUSH_STEP;
                    next_s.ram_wdata = ret_pc[7:0];
                end
                if (s.op == `BCM_OP_LONG_CALL && s.mc == `BCM_MC_OPND2) begin
                    next_s.ram_we = 1'b1;
                    next_s.ram_addr = STACK_POINTER_IN + `BCM_PUSH_TOTAL;
                    next_s.ram_wdata = ret_pc[15:8];
                end
                if (s.mc == dec.last) begin
                    next_s.mc = 2'h0;
                    next_s.done = 1'b1;
                    next_s.illegal = !dec.legal;
                    case (s.op)
                        `BCM_OP_IJMP: next_s.pc = {8'h00, ACCUMULATOR_IN} + DATA_POINTER_IN;
                        `BCM_OP_LONG_JUMP: next_s.pc = {s.opnd1, s.opnd2};
                        `BCM_OP_LONG_CALL: begin
                            next_s.pc = {s.opnd1, s.opnd2};
                            next_s.stack_pointer_we = 1'b1;
                            next_s.stack_pointer_wdata = STACK_POINTER_IN + `BCM_PUSH_TOTAL;
                        end
                        default: next_s.pc = taken ? seq_pc + sext(rel) : seq_pc;
                    endcase
                    if (s.op[7:3] == `BCM_OP_MOVAR) begin
                        next_s.accumulator_we = 1'b1;
                        next_s.accumulator_wdata = REG_IN;
                    end
                    next_s.code_addr = next_s.pc;
                end else begin
                    next_s.mc = s.mc + 2'h1;
                end
            end
            default: next_s.phase = bcm_pkg::PH_ADDR;
        endcase
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.pc <= `BCM_RESET_PC;
            s.code_addr <= `BCM_RESET_PC;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign CODE_RD = (s.phase == bcm_pkg::PH_ADDR) && fetch_byte;
    assign CODE_ADDR = s.code_addr;
    assign REG_SEL = s.op[2:0];
    assign BIT_ADDR = s.opnd1;
    assign PC = s.pc;
    assign ACCUMULATOR_WE = s.accumulator_we;
    assign ACCUMULATOR_WDATA = s.accumulator_wdata;
    assign RAM_WE = s.ram_we;
    assign RAM_ADDR = s.ram_addr;
    assign RAM_WDATA = s.ram_wdata;
    assign STACK_POINTER_WE = s.stack_pointer_we;
    assign STACK_POINTER_WDATA = s.stack_pointer_wdata;
    assign INSTR_DONE = s.done;
    assign ILLEGAL = s.illegal;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!rst_n);

    AST_IJMP: assert property (s.done && s.op == `BCM_OP_IJMP |->
        s.pc == {8'h00, $past(ACCUMULATOR_IN)} + $past(DATA_POINTER_IN) && $past(s.mc) == `BCM_LAST_2)
        else $error("indirect jump target wrong");
    AST_BIT_CLEAR: assert property (s.done && s.op == `BCM_OP_JUMP_BIT_CLEAR |->
        s.pc == $past(s.pc) + 16'h0003 + ($past(BIT_VALUE) ? 16'h0000 : sext(s.opnd2)))
        else $error("bit clear branch target wrong");
    AST_CARRY_CLEAR: assert property (s.done && s.op == `BCM_OP_JUMP_CARRY_CLEAR |->
        s.pc == $past(s.pc) + 16'h0002 + ($past(CARRY_IN) ? 16'h0000 : sext(s.opnd1)))
        else $error("carry clear branch target wrong");
    AST_NONZERO: assert property (s.done && s.op == `BCM_OP_JUMP_NONZERO |->
        s.pc == $past(s.pc) + 16'h0002 + ($past(ACCUMULATOR_IN) != 8'h00 ? sext(s.opnd1) : 16'h0000))
        else $error("nonzero branch target wrong");
    AST_ZERO: assert property (s.done && s.op == `BCM_OP_JUMP_ZERO |->
        s.pc == $past(s.pc) + 16'h0002 + ($past(ACCUMULATOR_IN) == 8'h00 ? sext(s.opnd1) : 16'h0000))
        else $error("zero branch target wrong");
    AST_REL_LEN: assert property (s.done && s.op == `BCM_OP_JUMP_ZERO |-> $past(s.mc) == `BCM_LAST_3)
        else $error("relative branch length wrong");
    AST_CALL_PUSH: assert property (s.ram_we && s.op == `BCM_OP_LONG_CALL && s.mc == `BCM_MC_OPND2 |->
        s.ram_addr == $past(STACK_POINTER_IN) + 8'h01 && s.ram_wdata == ret_pc[7:0]
        ##4 (s.ram_we && s.ram_addr == $past(s.ram_addr, 4) + 8'h01 && s.ram_wdata == ret_pc[15:8]))
        else $error("call push order wrong");
    AST_CALL_JUMP: assert property (s.done && s.op == `BCM_OP_LONG_CALL |->
        s.pc == {s.opnd1, s.opnd2} && s.stack_pointer_we &&
        s.stack_pointer_wdata == $past(STACK_POINTER_IN) + 8'h02)
        else $error("call target or pointer wrong");
    AST_LONG_JUMP: assert property (s.done && s.op == `BCM_OP_LONG_JUMP |->
        s.pc == {s.opnd1, s.opnd2} && !s.stack_pointer_we && !s.accumulator_we)
        else $error("long jump target wrong");
    AST_MOVE: assert property (s.done && s.op[7:3] == `BCM_OP_MOVAR |->
        s.accumulator_we && s.accumulator_wdata == $past(REG_IN) && s.pc == $past(s.pc) + 16'h0001 && !s.ram_we)
        else $error("register move wrong");
    AST_CARRY_SET: assert property (s.done && s.op == `BCM_OP_JUMP_CARRY_SET |->
        s.pc == $past(s.pc) + 16'h0002 + ($past(CARRY_IN) ? sext(s.opnd1) : 16'h0000))
        else $error("carry set branch target wrong");

    CVR_BIT_CLEAR_TAKEN: cover property (s.done && s.op == `BCM_OP_JUMP_BIT_CLEAR && $past(!BIT_VALUE));
    CVR_CALL: cover property (s.done && s.op == `BCM_OP_LONG_CALL);
    CVR_IJMP_CARRY: cover property (s.done && s.op == `BCM_OP_IJMP && s.pc[15:8] != $past(DATA_POINTER_IN[15:8]));
    CVR_MOVE: cover property (s.done && s.op[7:3] == `BCM_OP_MOVAR);

endmodule // bcm_exec

//--- hw/bcm_consts.svh
// constants for the branch, call and move execution block
`ifndef BCM_CONSTS_SVH
`define BCM_CONSTS_SVH
`define BCM_OP_IJMP 8'h73
`define BCM_OP_JUMP_BIT_CLEAR 8'h30
`define BCM_OP_JUMP_CARRY_CLEAR 8'h50
`define BCM_OP_JUMP_CARRY_SET 8'h40
`define BCM_OP_JUMP_NONZERO 8'h70
`define BCM_OP_JUMP_ZERO 8'h60
`define BCM_OP_LONG_CALL 8'h12
`define BCM_OP_LONG_JUMP 8'h02
`define BCM_OP_MOVAR 5'h1D
`define BCM_LEN_1 2'h1
`define BCM_LEN_2 2'h2
`define BCM_LEN_3 2'h3
`define BCM_LAST_1 2'h0
`define BCM_LAST_2 2'h1
`define BCM_LAST_3 2'h2
`define BCM_LAST_4 2'h3
`define BCM_MC_OPND1 2'h1
`define BCM_MC_OPND2 2'h2
`define BCM_MC_LAST 2'h3
`define BCM_RESET_PC 16'h0000
`define BCM_PUSH_STEP 8'h01
`define BCM_PUSH_TOTAL 8'h02
`endif

//--- hw/bcm_pkg.sv
// types of the branch, call and move execution block
package bcm_pkg;
    // four clocks per machine cycle, gray along the path
    typedef enum logic [1:0] {
        PH_ADDR = 2'h0,
        PH_WAIT = 2'h1,
        PH_TAKE = 2'h3,
        PH_WORK = 2'h2
    } bcm_phase_t;

    typedef struct packed {
        logic [1:0] len;
        logic [1:0] last;
        logic legal;
    } bcm_dec_t;

    typedef struct packed {
        bcm_phase_t phase;
        logic [1:0] mc;
        logic [7:0] op;
        logic [7:0] opnd1;
        logic [7:0] opnd2;
        logic [15:0] pc;
        logic [15:0] code_addr;
        logic accumulator_we;
        logic [7:0] accumulator_wdata;
        logic ram_we;
        logic [7:0] ram_addr;
        logic [7:0] ram_wdata;
        logic stack_pointer_we;
        logic [7:0] stack_pointer_wdata;
        logic done;
        logic illegal;
    } bcm_state_t;
endpackage

//--- bench/bcm_mem_model.sv
// behavioural program memory and stack ram facing the execution block
`timescale 1ns/1ps
module bcm_mem_model (
    input wire logic CLOCK,
    input wire logic CODE_RD,
    input wire logic [15:0] CODE_ADDR,
    output logic [7:0] CODE_DATA,
    input wire logic RAM_WE,
    input wire logic [7:0] RAM_ADDR,
    input wire logic [7:0] RAM_WDATA
);
    logic [7:0] mem [0:65535];
    logic [7:0] ram [0:255];
    logic [15:0] addr;
    logic pend = 1'b0;
    // byte valid only in the second clock after the read; flips otherwise so stale data cannot pass
    always @(posedge CLOCK) begin
        if (pend) CODE_DATA <= mem[addr];
        else CODE_DATA <= ~CODE_DATA;
        pend <= CODE_RD;
        addr <= CODE_ADDR;
        if (RAM_WE) ram[RAM_ADDR] <= RAM_WDATA;
    end
endmodule // bcm_mem_model

//--- bench/branch_call_move_exec_test.sv
// self-checking bench for the branch, call and move execution block
`timescale 1ns/1ps
`include "bcm_consts.svh"
module branch_call_move_exec_test;
    logic clock, rstn, carry_in, bit_value, code_rd, ram_we, instr_done, illegal;
    logic accumulator_we, stack_pointer_we;
    logic [7:0] accumulator_in, stack_pointer_in, reg_in, code_data, bit_addr, ram_addr, ram_wdata;
    logic [7:0] accumulator_wdata, stack_pointer_wdata;
    logic [15:0] data_pointer_in, code_addr, pc, pc_now, a, ret;
    logic [2:0] reg_sel;
    logic [7:0] op, rel, b2;
    logic tk;
    logic [7:0] ops [5] = '{`BCM_OP_JUMP_BIT_CLEAR, `BCM_OP_JUMP_CARRY_CLEAR, `BCM_OP_JUMP_CARRY_SET,
        `BCM_OP_JUMP_NONZERO, `BCM_OP_JUMP_ZERO};
    int miscompares = 0;
    int n_tests = 0;
    int r;
    bcm_exec dut_u (.CLOCK(clock), .RSTN(rstn), .CODE_RD(code_rd), .CODE_ADDR(code_addr),
        .CODE_DATA(code_data), .ACCUMULATOR_IN(accumulator_in), .DATA_POINTER_IN(data_pointer_in),
        .CARRY_IN(carry_in), .STACK_POINTER_IN(stack_pointer_in), .REG_SEL(reg_sel), .REG_IN(reg_in),
        .BIT_ADDR(bit_addr), .BIT_VALUE(bit_value), .PC(pc), .ACCUMULATOR_WE(accumulator_we),
        .ACCUMULATOR_WDATA(accumulator_wdata), .RAM_WE(ram_we), .RAM_ADDR(ram_addr), .RAM_WDATA(ram_wdata),
        .STACK_POINTER_WE(stack_pointer_we), .STACK_POINTER_WDATA(stack_pointer_wdata),
        .INSTR_DONE(instr_done), .ILLEGAL(illegal));
    bcm_mem_model mem_u (.CLOCK(clock), .CODE_RD(code_rd), .CODE_ADDR(code_addr), .CODE_DATA(code_data),
        .RAM_WE(ram_we), .RAM_ADDR(ram_addr), .RAM_WDATA(ram_wdata));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // relative destination: offset is signed and added to the address of the next instruction
    function automatic logic [15:0] rel_dest(logic [15:0] p, logic [15:0] len, logic [7:0] d, logic t);
        return p + len + (t ? {{8{d[7]}}, d} : 16'h0000);
    endfunction
    // places one instruction at the current address and waits for it to retire
    task automatic step(input logic [7:0] o, input logic [7:0] x2, input logic [7:0] x3,
        input logic [15:0] exp_pc, input int mc, input bit chk_len);
        int n = 0;
        int n_accum = 0;
        int n_ram = 0;
        int n_stack = 0;
        mem_u.mem[pc_now] = o;
        mem_u.mem[pc_now + 16'h0001] = x2;
        mem_u.mem[pc_now + 16'h0002] = x3;
        while (n < 200) begin
            @(negedge clock);
            n++;
            n_accum += (accumulator_we === 1'b1);
            n_ram += (ram_we === 1'b1);
            n_stack += (stack_pointer_we === 1'b1);
            if (instr_done === 1'b1) break;
        end
        if (n >= 200) begin
            miscompares++;
            test_done();
        end
        check(pc, exp_pc);
        if (chk_len) check(n, mc * 4);
        check(n_accum, o[7:3] == `BCM_OP_MOVAR);
        check(n_ram, (o == `BCM_OP_LONG_CALL) ? 2 : 0);
        check(n_stack, o == `BCM_OP_LONG_CALL);
        // 8'hA5 is the only unsupported opcode that the bench places
        check(illegal, o == 8'hA5);
        pc_now = exp_pc;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        r = $urandom(32'hDB8B);
        rstn = 1'b0;
        accumulator_in = 8'h00;
        data_pointer_in = 16'h0000;
        carry_in = 1'b0;
        bit_value = 1'b0;
        stack_pointer_in = 8'h07;
        reg_in = 8'h00;
        pc_now = 16'h0000;
        mem_u.mem[0] = 8'hA5;
        repeat (8) @(negedge clock);
        rstn = 1'b1;
        // first retirement length depends on reset release, so not timed
        step(8'hA5, 8'h00, 8'h00, 16'h0001, 1, 1'b0);
        for (int i = 0; i < 60; i++) begin
            op = ops[$urandom % 5];
            rel = (i < 2) ? ((i == 0) ? 8'h7F : 8'h80) : 8'($urandom);
            b2 = 8'($urandom);
            accumulator_in = ($urandom % 2) ? 8'($urandom) : 8'h00;
            carry_in = 1'($urandom);
            bit_value = 1'($urandom);
            case (op)
                `BCM_OP_JUMP_BIT_CLEAR: tk = ~bit_value;
                `BCM_OP_JUMP_CARRY_CLEAR: tk = ~carry_in;
                `BCM_OP_JUMP_CARRY_SET: tk = carry_in;
                `BCM_OP_JUMP_NONZERO: tk = |accumulator_in;
                default: tk = ~|accumulator_in;
            endcase
            if (op == `BCM_OP_JUMP_BIT_CLEAR) begin
                step(op, b2, rel, rel_dest(pc_now, 16'h0003, rel, tk), 4, 1'b1);
                check(bit_addr, b2);
            end else begin
                step(op, rel, 8'h00, rel_dest(pc_now, 16'h0002, rel, tk), 3, 1'b1);
            end
        end
        $display("test relative branches done");
        for (int i = 0; i < 10; i++) begin
            accumulator_in = (i == 0) ? 8'hFF : ((i == 1) ? 8'h80 : 8'($urandom));
            data_pointer_in = (i == 0) ? 16'hFFF0 : ((i == 1) ? 16'h12F0 : 16'($urandom));
            step(`BCM_OP_IJMP, 8'h00, 8'h00, data_pointer_in + {8'h00, accumulator_in}, 2, 1'b1);
            a = (i == 0) ? 16'hFFFF : 16'($urandom);
            step(`BCM_OP_LONG_JUMP, a[15:8], a[7:0], a, 4, 1'b1);
            stack_pointer_in = (i == 0) ? 8'hFE : 8'($urandom);
            ret = pc_now + 16'h0003;
            a = 16'($urandom);
            step(`BCM_OP_LONG_CALL, a[15:8], a[7:0], a, 4, 1'b1);
            check(mem_u.ram[stack_pointer_in + 8'h01], ret[7:0]);
            check(mem_u.ram[stack_pointer_in + 8'h02], ret[15:8]);
            // the pointer wraps at eight bits, so cut the sum before the wide compare
            check(stack_pointer_wdata, 8'(stack_pointer_in + 8'h02));
            reg_in = 8'($urandom);
            op = {`BCM_OP_MOVAR, 3'($urandom)};
            step(op, 8'h00, 8'h00, pc_now + 16'h0001, 1, 1'b1);
            check(reg_sel, op[2:0]);
            check(accumulator_wdata, reg_in);
        end
        $display("test jumps calls and moves done");
        test_done();
    end
endmodule // branch_call_move_exec_test
